// ### core/date_time_mem.v
// Four-word date/time store with registered read data
`timescale 1ns/1ps
module date_time_mem (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        wr_en,
  input  wire [1:0]  wr_idx,
  input  wire [15:0] wr_data,
  input  wire [1:0]  rd_idx,
  output reg  [15:0] rd_data_ff
);

  reg [15:0] word_ff [0:3];
  integer    i;

  always @(posedge sys_clk) begin
    if (srst) begin
      for (i = 0; i < 4; i = i + 1) begin
        word_ff[i] <= 16'h0000;
      end
      rd_data_ff <= 16'h0000;
    end else begin
      if (wr_en) begin
        word_ff[wr_idx] <= wr_data;
      end
      // Old data on a same-cycle read of the written word
      rd_data_ff <= word_ff[rd_idx];
    end
  end

endmodule

// ### core/insulation_monitor_modbus_regs.v
// Modbus-facing register bank of the insulation monitor
`timescale 1ns/1ps
`include "insulation_regs_defines.vh"
module insulation_monitor_modbus_regs (
  input  wire        sys_clk,
  input  wire        srst,
  // One register access per request, from the frame parser
  input  wire        req_valid,
  input  wire [7:0]  req_func,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  output reg         rsp_valid_ff,
  output reg  [15:0] rsp_rdata_ff,
  output reg         rsp_exception_ff,
  output reg  [7:0]  rsp_exc_code_ff,
  // Device state from the measurement side
  input  wire [7:0]  fw_major,
  input  wire [7:0]  fw_minor,
  input  wire [15:0] fw_quality,
  input  wire [7:0]  error_code,
  input  wire [2:0]  fault_state,
  input  wire        self_test,
  input  wire        injection_inhibited,
  input  wire [31:0] resistance_ohm,
  input  wire [31:0] capacitance_f,
  input  wire [31:0] ground_voltage_v,
  input  wire [2:0]  r_qualifier,
  input  wire [2:0]  c_qualifier
);

  localparam [15:0] DT_BASE  = `ADDR_DATE_TIME_0;
  localparam [31:0] NAN_WORD = `FLOAT_NAN;

  wire        is_write;
  wire        in_date_time;
  wire        known_addr;
  wire        invalid_meas;
  wire [1:0]  dt_idx;
  wire [15:0] dt_rdata;
  // One hit per read-only word, kept apart so the refusal path is easy to audit
  wire        hit_product_id;
  wire        hit_fw_hi;
  wire        hit_fw_lo;
  wire        hit_product_state;
  wire        hit_res_hi;
  wire        hit_res_lo;
  wire        hit_cap_hi;
  wire        hit_cap_lo;
  wire        hit_injection;
  wire        hit_gv_hi;
  wire        hit_gv_lo;
  wire        hit_r_qual;
  wire        hit_c_qual;
  wire        ro_hit;

  reg         st_valid_ff;
  reg [15:0]  st_addr_ff;
  reg         st_exc_ff;
  reg [7:0]   st_exc_code_ff;
  reg [15:0]  nxt_rdata;
  reg [7:0]   state_code;
  reg [7:0]   nxt_exc_code;
  reg         nxt_exc;

  // Frame address is decoded directly, never the listed number
  assign is_write = (req_func == `FUNC_WRITE_SINGLE) || (req_func == `FUNC_WRITE_MULTIPLE);

  assign in_date_time = (req_addr >= `ADDR_DATE_TIME_0) && (req_addr <= `ADDR_DATE_TIME_3);
  // Base sits at an odd address, so low bits minus one give words 0 to 3
  assign dt_idx       = req_addr[1:0] - DT_BASE[1:0];

  assign hit_product_id    = (req_addr == `ADDR_PRODUCT_ID);
  assign hit_fw_hi         = (req_addr == `ADDR_FW_VERSION_HI);
  assign hit_fw_lo         = (req_addr == `ADDR_FW_VERSION_LO);
  assign hit_product_state = (req_addr == `ADDR_PRODUCT_STATE);
  assign hit_res_hi        = (req_addr == `ADDR_RESISTANCE_HI);
  assign hit_res_lo        = (req_addr == `ADDR_RESISTANCE_LO);
  assign hit_cap_hi        = (req_addr == `ADDR_CAPACITANCE_HI);
  assign hit_cap_lo        = (req_addr == `ADDR_CAPACITANCE_LO);
  assign hit_injection     = (req_addr == `ADDR_INJECTION_STATE);
  assign hit_gv_hi         = (req_addr == `ADDR_GROUND_V_HI);
  assign hit_gv_lo         = (req_addr == `ADDR_GROUND_V_LO);
  assign hit_r_qual        = (req_addr == `ADDR_R_QUALIFIER);
  assign hit_c_qual        = (req_addr == `ADDR_C_QUALIFIER);

  assign ro_hit = hit_product_id | hit_fw_hi | hit_fw_lo | hit_product_state |
                  hit_res_hi | hit_res_lo | hit_cap_hi | hit_cap_lo |
                  hit_injection | hit_gv_hi | hit_gv_lo |
                  hit_r_qual | hit_c_qual;

  assign known_addr = in_date_time || ro_hit;

  // Only the date/time words take a write; the rest stay untouched
  date_time_mem u_date_time (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .wr_en      (req_valid && is_write && in_date_time),
    .wr_idx     (dt_idx),
    .wr_data    (req_wdata),
    .rd_idx     (dt_idx),
    .rd_data_ff (dt_rdata)
  );

  // Both read functions share one decode and one map
  always @* begin
    nxt_exc      = 1'b0;
    nxt_exc_code = 8'h00;
    case (req_func)
      `FUNC_READ_HOLDING, `FUNC_READ_INPUT: begin
        if (!known_addr) begin
          nxt_exc      = 1'b1;
          nxt_exc_code = `EXC_ILLEGAL_ADDRESS;
        end
      end
      `FUNC_WRITE_SINGLE, `FUNC_WRITE_MULTIPLE: begin
        // Read-only and unmapped words are refused alike
        if (!in_date_time) begin
          nxt_exc      = 1'b1;
          nxt_exc_code = `EXC_ILLEGAL_ADDRESS;
        end
      end
      default: begin
        nxt_exc      = 1'b1;
        nxt_exc_code = `EXC_ILLEGAL_FUNCTION;
      end
    endcase
  end

  // Stage one: capture request while the date/time word is fetched
  always @(posedge sys_clk) begin
    if (srst) begin
      st_valid_ff    <= 1'b0;
      st_addr_ff     <= 16'h0000;
      st_exc_ff      <= 1'b0;
      st_exc_code_ff <= 8'h00;
    end else begin
      st_valid_ff    <= req_valid;
      st_addr_ff     <= req_addr;
      st_exc_ff      <= nxt_exc;
      st_exc_code_ff <= nxt_exc_code;
    end
  end

  // Self-test and inhibition outrank the reported fault code
  always @* begin
    if (self_test) begin
      state_code = `STATE_SELF_TEST;
    end else if (injection_inhibited) begin
      state_code = `STATE_INJ_DISABLED;
    end else begin
      state_code = {5'h00, fault_state};
    end
  end

  assign invalid_meas = injection_inhibited || self_test;

  // Stage two: live values are sampled here, so reads see the latest state
  always @* begin
    case (st_addr_ff)
      `ADDR_PRODUCT_ID: begin
        nxt_rdata = `PRODUCT_ID_DEFAULT;
      end
      `ADDR_FW_VERSION_HI: begin
        nxt_rdata = {fw_major, fw_minor};
      end
      `ADDR_FW_VERSION_LO: begin
        nxt_rdata = fw_quality;
      end
      `ADDR_PRODUCT_STATE: begin
        nxt_rdata = {error_code, state_code};
      end
      // A split NaN read still rebuilds the full pattern from both halves
      `ADDR_RESISTANCE_HI: begin
        nxt_rdata = invalid_meas ? NAN_WORD[31:16] : resistance_ohm[31:16];
      end
      `ADDR_RESISTANCE_LO: begin
        nxt_rdata = invalid_meas ? NAN_WORD[15:0] : resistance_ohm[15:0];
      end
      `ADDR_CAPACITANCE_HI: begin
        nxt_rdata = invalid_meas ? NAN_WORD[31:16] : capacitance_f[31:16];
      end
      `ADDR_CAPACITANCE_LO: begin
        nxt_rdata = invalid_meas ? NAN_WORD[15:0] : capacitance_f[15:0];
      end
      `ADDR_INJECTION_STATE: begin
        nxt_rdata = injection_inhibited ? `INJ_DEACTIVATED : `INJ_ACTIVE;
      end
      `ADDR_GROUND_V_HI: begin
        nxt_rdata = invalid_meas ? NAN_WORD[31:16] : ground_voltage_v[31:16];
      end
      `ADDR_GROUND_V_LO: begin
        nxt_rdata = invalid_meas ? NAN_WORD[15:0] : ground_voltage_v[15:0];
      end
      `ADDR_R_QUALIFIER: begin
        nxt_rdata = {13'h0000, r_qualifier};
      end
      `ADDR_C_QUALIFIER: begin
        nxt_rdata = {13'h0000, c_qualifier};
      end
      // Only date/time words arrive here without an exception
      default: begin
        nxt_rdata = dt_rdata;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      rsp_valid_ff     <= 1'b0;
      rsp_rdata_ff     <= 16'h0000;
      rsp_exception_ff <= 1'b0;
      rsp_exc_code_ff  <= 8'h00;
    end else begin
      rsp_valid_ff     <= st_valid_ff;
      // Exceptions return zero data so nothing leaks from a refused access
      rsp_rdata_ff     <= st_exc_ff ? 16'h0000 : nxt_rdata;
      rsp_exception_ff <= st_valid_ff && st_exc_ff;
      rsp_exc_code_ff  <= st_valid_ff ? st_exc_code_ff : 8'h00;
    end
  end

endmodule

// ### core/insulation_regs_defines.vh
// Constants for the insulation monitor Modbus register bank
// Overview of operation
// - Decode frame address; listed register number is frame address plus one.
// - Version word one: major revision high byte, minor revision low byte.
// - Version word two holds the whole quality revision number.
// - Product status word high byte carries the current error code.
// - Status low byte: 0x00 normal through 0x07 overvoltage state codes.
// - Resistance float reads NaN while injection inhibited or self-test runs.
// - Capacitance float reads NaN while injection inhibited or self-test runs.
// - Ground voltage float reads NaN while injection inhibited or self-test runs.
// - Injection status reads 0 when active, 1 when deactivated.
// - Qualifiers: 0 equal, 1 under, 2 over, 3 strictly below, 4 strictly above.
// - Function 0x03 and 0x04 read the same map with identical contents.
`ifndef INSULATION_REGS_DEFINES_VH
`define INSULATION_REGS_DEFINES_VH

// Frame addresses (register number minus one)
`define ADDR_PRODUCT_ID      16'h0064
`define ADDR_FW_VERSION_HI   16'h0066
`define ADDR_FW_VERSION_LO   16'h0067
`define ADDR_DATE_TIME_0     16'h0069
`define ADDR_DATE_TIME_3     16'h006c
`define ADDR_PRODUCT_STATE   16'h006d
`define ADDR_RESISTANCE_HI   16'h03e8
`define ADDR_RESISTANCE_LO   16'h03e9
`define ADDR_CAPACITANCE_HI  16'h03ea
`define ADDR_CAPACITANCE_LO  16'h03eb
`define ADDR_INJECTION_STATE 16'h03f0
`define ADDR_GROUND_V_HI     16'h03f1
`define ADDR_GROUND_V_LO     16'h03f2
`define ADDR_R_QUALIFIER     16'h03f3
`define ADDR_C_QUALIFIER     16'h03f4

// Function codes
`define FUNC_READ_HOLDING    8'h03
`define FUNC_READ_INPUT      8'h04
`define FUNC_WRITE_SINGLE    8'h06
`define FUNC_WRITE_MULTIPLE  8'h10

// Exception codes
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS  8'h02

// Product status low-byte codes
`define STATE_NORMAL         8'h00
`define STATE_SELF_TEST      8'h01
`define STATE_INSUL_FAULT    8'h02
`define STATE_INJ_DISCONN    8'h03
`define STATE_CAP_OVER       8'h04
`define STATE_INOPERATIVE    8'h05
`define STATE_INJ_DISABLED   8'h06
`define STATE_OVERVOLTAGE    8'h07

// Injection status values
`define INJ_ACTIVE           16'h0000
`define INJ_DEACTIVATED      16'h0001

// Qualifier codes
`define QUAL_EQUAL           3'h0
`define QUAL_UNDER           3'h1
`define QUAL_OVER            3'h2
`define QUAL_STRICTLY_BELOW  3'h3
`define QUAL_STRICTLY_ABOVE  3'h4

// Float quiet NaN returned for invalid readings
`define FLOAT_NAN            32'hffc00000

// Arbitrary neutral product identifier
`define PRODUCT_ID_DEFAULT   16'h0a5a

`endif

// ### tb/insulation_regs_monitor.sv
// Assertion checker for the register bank ports
`timescale 1ns/1ps
module insulation_regs_monitor (
  input wire        sys_clk,
  input wire        srst,
  input wire        req_valid,
  input wire [7:0]  req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire        rsp_valid_ff,
  input wire [15:0] rsp_rdata_ff,
  input wire        rsp_exception_ff,
  input wire [7:0]  rsp_exc_code_ff,
  input wire [7:0]  fw_major,
  input wire [7:0]  fw_minor,
  input wire [15:0] fw_quality,
  input wire [7:0]  error_code,
  input wire [2:0]  fault_state,
  input wire        self_test,
  input wire        injection_inhibited,
  input wire [31:0] resistance_ohm,
  input wire [31:0] capacitance_f,
  input wire [31:0] ground_voltage_v,
  input wire [2:0]  r_qualifier,
  input wire [2:0]  c_qualifier
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire rd = req_valid && (req_func == 8'h03 || req_func == 8'h04);
  wire nan = self_test || injection_inhibited;
  wire known = req_func inside {8'h03, 8'h04, 8'h06, 8'h10};
  wire dt = req_addr >= 16'h0069 && req_addr <= 16'h006c;
  property p_lat; req_valid |-> ##2 rsp_valid_ff; endproperty
  a_lat: assert property (p_lat) else $error("answer missing");
  property p_func; req_valid && !known |-> ##2 rsp_exception_ff && rsp_exc_code_ff == 8'h01;
  endproperty
  a_func: assert property (p_func) else $error("bad function accepted");
  property p_ro; req_valid && req_func == 8'h06 && !dt |-> ##2 rsp_exc_code_ff == 8'h02;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  property p_rnan; rd && req_addr == 16'h03e8 ##1 nan |-> ##1 rsp_rdata_ff == 16'hffc0;
  endproperty
  a_rnan: assert property (p_rnan) else $error("resistance not NaN");
  property p_cnan; rd && req_addr == 16'h03ea ##1 nan |-> ##1 rsp_rdata_ff == 16'hffc0;
  endproperty
  a_cnan: assert property (p_cnan) else $error("capacitance not NaN");
  property p_vnan; rd && req_addr == 16'h03f1 ##1 nan |-> ##1 rsp_rdata_ff == 16'hffc0;
  endproperty
  a_vnan: assert property (p_vnan) else $error("voltage not NaN");
  property p_ver;
    rd && req_addr == 16'h0066 |-> ##2 rsp_rdata_ff == {$past(fw_major), $past(fw_minor)};
  endproperty
  a_ver: assert property (p_ver) else $error("version word wrong");
  property p_err; rd && req_addr == 16'h006d |-> ##2 rsp_rdata_ff[15:8] == $past(error_code);
  endproperty
  a_err: assert property (p_err) else $error("error code wrong");
  property p_inj;
    rd && req_addr == 16'h03f0 |-> ##2 rsp_rdata_ff == {15'h0000, $past(injection_inhibited)};
  endproperty
  a_inj: assert property (p_inj) else $error("injection word wrong");
  property p_qual;
    rd && req_addr == 16'h03f3 |-> ##2 rsp_rdata_ff == {13'h0000, $past(r_qualifier)};
  endproperty
  a_qual: assert property (p_qual) else $error("qualifier wrong");
  c_rd: cover property (rd ##2 rsp_valid_ff);
  c_wr: cover property (req_valid && req_func == 8'h06 && dt ##2 !rsp_exception_ff);
  c_nan: cover property (rd && req_addr == 16'h03e8 ##1 nan);
endmodule
bind insulation_monitor_modbus_regs insulation_regs_monitor insulation_regs_monitor_inst (
  .sys_clk, .srst, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid_ff,
  .rsp_rdata_ff, .rsp_exception_ff, .rsp_exc_code_ff, .fw_major, .fw_minor, .fw_quality,
  .error_code, .fault_state, .self_test, .injection_inhibited, .resistance_ohm,
  .capacitance_f, .ground_voltage_v, .r_qualifier, .c_qualifier);

// ### tb/modbus_master_model.sv
// Behavioural Modbus master issuing one register access at a time
`timescale 1ns/1ps
module modbus_master_model (
  input  wire         sys_clk,
  output logic        req_valid,
  output logic [7:0]  req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // Caller gives the listed number; the frame carries number minus one
  task automatic access(input [7:0] f, input [15:0] num, input [15:0] d);
    @(posedge sys_clk);
    #2;
    req_valid = 1'b1;
    req_func = f;
    req_addr = num - 16'h0001;
    req_wdata = d;
    @(posedge sys_clk);
    #2;
    req_valid = 1'b0;
    // Released address and data lines do not keep the old value
    req_addr = ~req_addr;
    req_wdata = ~req_wdata;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, srst = 1, self_test = 0, injection_inhibited = 0;
  logic [7:0] fw_major = 0, fw_minor = 0, error_code = 0;
  logic [15:0] fw_quality = 0, wd;
  logic [2:0] fault_state = 0, r_qualifier = 0, c_qualifier = 0;
  logic [31:0] resistance_ohm = 0, capacitance_f = 0, ground_voltage_v = 0;
  logic req_valid, rsp_valid_ff, rsp_exception_ff;
  logic [7:0] req_func, rsp_exc_code_ff;
  logic [15:0] req_addr, req_wdata, rsp_rdata_ff;
  logic [15:0] dt [4] = '{default: 16'h0000};
  logic [15:0] amap [17] = '{16'h0064, 16'h0066, 16'h0067, 16'h0069, 16'h006a, 16'h006b,
    16'h006c, 16'h006d, 16'h03e8, 16'h03e9, 16'h03ea, 16'h03eb, 16'h03f0, 16'h03f1,
    16'h03f2, 16'h03f3, 16'h03f4};
  int error_cnt = 0, num_checks = 0, cyc = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  modbus_master_model modbus_master_model_inst (.sys_clk(sys_clk), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata));
  insulation_monitor_modbus_regs insulation_monitor_modbus_regs_inst (.*);
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc == 12000) begin error_cnt++; report_and_stop(); end
  task automatic chk(input string n, input [15:0] s, input [15:0] e);
    num_checks++;
    if (s !== e) begin error_cnt++; $display("[ERR] %s expected %h seen %h", n, e, s); end
  endtask
  function automatic [15:0] exp_rd(input [15:0] a);
    logic nan;
    nan = self_test | injection_inhibited;
    case (a)
      16'h0064: return 16'h0a5a;
      16'h0066: return {fw_major, fw_minor};
      16'h0067: return fw_quality;
      16'h0069, 16'h006a, 16'h006b, 16'h006c: return dt[a[1:0] - 2'd1];
      16'h006d: return {error_code, self_test ? 8'h01 : injection_inhibited ? 8'h06 :
                        {5'h00, fault_state}};
      16'h03e8: return nan ? 16'hffc0 : resistance_ohm[31:16];
      16'h03e9: return nan ? 16'h0000 : resistance_ohm[15:0];
      16'h03ea: return nan ? 16'hffc0 : capacitance_f[31:16];
      16'h03eb: return nan ? 16'h0000 : capacitance_f[15:0];
      16'h03f0: return {15'h0000, injection_inhibited};
      16'h03f1: return nan ? 16'hffc0 : ground_voltage_v[31:16];
      16'h03f2: return nan ? 16'h0000 : ground_voltage_v[15:0];
      16'h03f3: return {13'h0000, r_qualifier};
      default: return {13'h0000, c_qualifier};
    endcase
  endfunction
  task automatic xfer(input [7:0] f, input [15:0] a, input [15:0] d, input [7:0] code);
    modbus_master_model_inst.access(f, a + 16'h0001, d);
    @(posedge sys_clk);
    #2;
    chk("valid", {15'h0000, rsp_valid_ff}, 16'h0001);
    chk("exception", {15'h0000, rsp_exception_ff}, {15'h0000, code != 0});
    if (code != 0) chk("exc_code", {8'h00, rsp_exc_code_ff}, {8'h00, code});
    else if (f < 8'h05) chk("rdata", rsp_rdata_ff, exp_rd(a));
  endtask
  initial begin
    void'($urandom(32'h239b67cb));
    repeat (20) @(posedge sys_clk);
    #2 srst = 0;
    for (int r = 0; r < 40; r++) begin
      {self_test, injection_inhibited} = 2'($urandom);
      {fw_major, fw_minor, fw_quality, error_code} = 40'({$urandom, $urandom});
      fault_state = 3'($urandom);
      r_qualifier = 3'($urandom % 5);
      c_qualifier = 3'($urandom % 5);
      {resistance_ohm, capacitance_f, ground_voltage_v} = {$urandom, $urandom, $urandom};
      wd = 16'($urandom);
      xfer(r[1] ? 8'h10 : 8'h06, 16'h0069 + 16'(r % 4), wd, 8'h00);
      dt[r % 4] = wd;
      xfer(8'h06, amap[r % 17], wd, (r % 17 > 2 && r % 17 < 7) ? 8'h00 : 8'h02);
      if (r % 17 > 2 && r % 17 < 7) dt[amap[r % 17][1:0] - 2'd1] = wd;
      xfer(8'h08, 16'h0064, 16'h0000, 8'h01);
      xfer(8'h03, 16'h03ef, 16'h0000, 8'h02);
      foreach (amap[i]) xfer(r[0] ? 8'h04 : 8'h03, amap[i], 16'h0000, 8'h00);
    end
    report_and_stop();
  end
endmodule
